// ==== rtl/dma_index_colour_channel.sv ====
// Per-channel index steps, address counters and colour fill/key datapath
`timescale 1ns/1ns
module dma_index_colour_channel
  import dma_index_colour_pkg::*;
(
  // Clock, reset and clock enable
  input  wire logic                  ref_clk,
  input  wire logic                  reset,
  input  wire logic                  clk_en,
  // Register port
  input  wire logic [REG_ADDR_W-1:0] reg_addr,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  input  wire logic [REG_W-1:0]      reg_wdata,
  output logic      [REG_W-1:0]      reg_rdata,
  output logic                       reg_rvalid,
  // Active channel and its control words
  input  wire logic [CH_W-1:0]       active_ch,
  input  wire logic [REG_W-1:0]      channel_control_word,
  input  wire logic [REG_W-1:0]      channel_control_word_two,
  input  elem_size_type              elem_size,
  input  addr_mode_type              src_mode,
  input  addr_mode_type              dst_mode,
  // Address counters
  input  wire logic                  load_start,
  input  wire logic [ADDR_W-1:0]     src_start,
  input  wire logic [ADDR_W-1:0]     dst_start,
  input  wire logic                  src_access,
  input  wire logic                  src_frame_end,
  input  wire logic                  dst_access,
  input  wire logic                  dst_frame_end,
  output logic      [ADDR_W-1:0]     src_addr,
  output logic      [ADDR_W-1:0]     dst_addr,
  // Element datapath
  input  wire logic [DATA_W-1:0]     src_data,
  input  wire logic                  src_data_valid,
  output logic      [DATA_W-1:0]     dst_data,
  output logic                       dst_write
);

  // Per-channel register views
  logic [REG_W-1:0]  src_frame_arr [CHAN_COUNT];
  logic [REG_W-1:0]  src_elem_arr [CHAN_COUNT];
  logic [REG_W-1:0]  dst_elem_arr [CHAN_COUNT];
  logic [REG_W-1:0]  dst_frame_arr [CHAN_COUNT];
  logic [REG_W-1:0]  col_l_arr [CHAN_COUNT];
  logic [REG_W-1:0]  col_u_arr [CHAN_COUNT];
  logic [ADDR_W-1:0] src_arr [CHAN_COUNT];
  logic [ADDR_W-1:0] dst_arr [CHAN_COUNT];

  // Shared stepping and colour terms of the active channel
  logic [ADDR_W-1:0] size_bytes;
  logic [REG_W-1:0]  dst_ei;
  logic [REG_W-1:0]  dst_fi;
  logic [ADDR_W-1:0] src_delta;
  logic [ADDR_W-1:0] dst_delta;
  logic [DATA_W-1:0] fill_pat;
  logic              key_match;
  logic              fill_on;
  logic              transparent_on;
  logic              sep_index;

  // Widen a signed byte step to the address width
  function automatic logic [ADDR_W-1:0] sext(input logic [REG_W-1:0] v);
    sext = {{(ADDR_W-REG_W){v[REG_W-1]}}, v};
  endfunction

  // Address delta for one access in the chosen mode
  function automatic logic [ADDR_W-1:0] step(input addr_mode_type m,
                                             input logic [ADDR_W-1:0] sz,
                                             input logic [REG_W-1:0] ei,
                                             input logic [REG_W-1:0] fi,
                                             input logic fe);
    case (m)
      mode_constant:     step = '0;
      mode_post_inc:     step = sz;
      mode_single_index: step = sext(ei);
      mode_double_index: step = fe ? sext(fi) : sext(ei);
      default:           step = '0;
    endcase
  endfunction

  // Stepping terms, destination steps chosen by control bit 10
  always_comb
  begin
    sep_index      = channel_control_word[CTRL_SEP_INDEX_BIT];
    fill_on        = channel_control_word_two[CTRL2_FILL_BIT];
    transparent_on = channel_control_word_two[CTRL2_TRANSPARENT_BIT];
    size_bytes     = ADDR_W'(32'h1 << elem_size);
    dst_ei         = sep_index ? dst_elem_arr[active_ch] : src_elem_arr[active_ch];
    dst_fi         = sep_index ? dst_frame_arr[active_ch] : src_frame_arr[active_ch];
    src_delta      = step(src_mode, size_bytes, src_elem_arr[active_ch],
                          src_frame_arr[active_ch], src_frame_end);
    dst_delta      = step(dst_mode, size_bytes, dst_ei, dst_fi, dst_frame_end);
  end

  // Fill pattern and colour key sized by element type
  always_comb
  begin
    case (elem_size)
      byte_access:
      begin
        fill_pat  = {24'h00_0000, col_l_arr[active_ch][7:0]};
        key_match = src_data[7:0] == col_l_arr[active_ch][7:0];
      end
      halfword_access:
      begin
        fill_pat  = {16'h0000, col_l_arr[active_ch]};
        key_match = src_data[15:0] == col_l_arr[active_ch];
      end
      word_access:
      begin
        fill_pat  = {col_u_arr[active_ch], col_l_arr[active_ch]};
        key_match = src_data == {col_u_arr[active_ch], col_l_arr[active_ch]};
      end
      default:
      begin
        fill_pat  = '0;
        key_match = 1'b0;
      end
    endcase
  end

  // One register set per channel at a 0x40-byte stride
  for (genvar ch = 0; ch < CHAN_COUNT; ch++)
  begin : g_chan
    logic              wr_sel;
    logic              act;
    logic [REG_W-1:0]  src_frame, src_elem, dst_elem, dst_frame, col_l, col_u;
    logic [REG_W-1:0]  next_src_frame, next_src_elem, next_dst_elem, next_dst_frame;
    logic [REG_W-1:0]  next_col_l, next_col_u;
    logic [ADDR_W-1:0] src_cnt, dst_cnt, next_src_cnt, next_dst_cnt;

    assign wr_sel = reg_wr && (reg_addr[REG_ADDR_W-1:OFF_W] == CH_W'(ch));
    assign act    = active_ch == CH_W'(ch);

    // Register writes and counter advance
    always_comb
    begin
      next_src_frame = src_frame;
      next_src_elem  = src_elem;
      next_dst_elem  = dst_elem;
      next_dst_frame = dst_frame;
      next_col_l   = col_l;
      next_col_u   = col_u;
      next_src_cnt = src_cnt;
      next_dst_cnt = dst_cnt;
      if (wr_sel)
      begin
        case (reg_addr[OFF_W-1:0])
          OFF_SRC_FRAME:   next_src_frame = reg_wdata;
          OFF_SRC_ELEMENT: next_src_elem  = reg_wdata;
          OFF_DST_ELEMENT: next_dst_elem  = reg_wdata;
          OFF_DST_FRAME:   next_dst_frame = reg_wdata;
          OFF_COLOUR_LOW:  next_col_l = reg_wdata;
          OFF_COLOUR_HIGH: next_col_u = reg_wdata;
          default:         next_src_frame = src_frame;
        endcase
      end
      if (act && load_start)
      begin
        next_src_cnt = src_start;
        next_dst_cnt = dst_start;
      end
      else if (act)
      begin
        if (src_access)
        begin
          next_src_cnt = src_cnt + src_delta;
        end
        if (dst_access)
        begin
          next_dst_cnt = dst_cnt + dst_delta;
        end
      end
    end

    // Channel state registers
    always_ff @(posedge ref_clk)
    begin
      if (reset)
      begin
        src_frame <= REG_RESET;
        src_elem  <= REG_RESET;
        dst_elem  <= REG_RESET;
        dst_frame <= REG_RESET;
        col_l   <= REG_RESET;
        col_u   <= REG_RESET;
        src_cnt <= ADDR_RESET;
        dst_cnt <= ADDR_RESET;
      end
      else if (clk_en)
      begin
        src_frame <= next_src_frame;
        src_elem  <= next_src_elem;
        dst_elem  <= next_dst_elem;
        dst_frame <= next_dst_frame;
        col_l   <= next_col_l;
        col_u   <= next_col_u;
        src_cnt <= next_src_cnt;
        dst_cnt <= next_dst_cnt;
      end
    end

    assign src_frame_arr[ch] = src_frame;
    assign src_elem_arr[ch]  = src_elem;
    assign dst_elem_arr[ch]  = dst_elem;
    assign dst_frame_arr[ch] = dst_frame;
    assign col_l_arr[ch] = col_l;
    assign col_u_arr[ch] = col_u;
    assign src_arr[ch]   = src_cnt;
    assign dst_arr[ch]   = dst_cnt;
  end

  // Scheduled addresses of the active channel
  assign src_addr = src_arr[active_ch];
  assign dst_addr = dst_arr[active_ch];

  // Readback and datapath next values
  logic [REG_W-1:0]      next_rdata;
  logic                  next_rvalid;
  logic [DATA_W-1:0]     next_dst_data;
  logic                  next_dst_write;
  logic [CH_W-1:0]       rd_ch;

  always_comb
  begin
    rd_ch       = reg_addr[REG_ADDR_W-1:OFF_W];
    next_rvalid = reg_rd;
    next_rdata  = reg_rdata;
    if (reg_rd)
    begin
      case (reg_addr[OFF_W-1:0])
        OFF_SRC_FRAME:   next_rdata = src_frame_arr[rd_ch];
        OFF_SRC_ELEMENT: next_rdata = src_elem_arr[rd_ch];
        OFF_SRC_SNAP:    next_rdata = src_arr[rd_ch][REG_W-1:0];
        OFF_DST_SNAP:    next_rdata = dst_arr[rd_ch][REG_W-1:0];
        OFF_DST_ELEMENT: next_rdata = dst_elem_arr[rd_ch];
        OFF_DST_FRAME:   next_rdata = dst_frame_arr[rd_ch];
        OFF_COLOUR_LOW:  next_rdata = col_l_arr[rd_ch];
        OFF_COLOUR_HIGH: next_rdata = col_u_arr[rd_ch];
        default:         next_rdata = '0;
      endcase
    end
    next_dst_data  = dst_data;
    next_dst_write = 1'b0;
    if (src_data_valid)
    begin
      if (fill_on)
      begin
        next_dst_data  = fill_pat;
        next_dst_write = 1'b1;
      end
      else if (transparent_on && key_match)
      begin
        next_dst_write = 1'b0;
      end
      else
      begin
        next_dst_data  = src_data;
        next_dst_write = 1'b1;
      end
    end
  end

  // Readback and datapath registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      reg_rdata  <= REG_RESET;
      reg_rvalid <= 1'b0;
      dst_data   <= '0;
      dst_write  <= 1'b0;
    end
    else if (clk_en)
    begin
      reg_rdata  <= next_rdata;
      reg_rvalid <= next_rvalid;
      dst_data   <= next_dst_data;
      dst_write  <= next_dst_write;
    end
  end

  // Checks on the behaviour above
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  sequence seq_frame_write;
    clk_en && reg_wr && reg_addr[OFF_W-1:0] == OFF_SRC_FRAME;
  endsequence

  sequence seq_same_read;
    clk_en && reg_rd && !reg_wr && $stable(reg_addr);
  endsequence

  chk_stride_readback: assert property (
    seq_frame_write ##1 seq_same_read |=> reg_rdata == $past(reg_wdata, 2))
    else $error("frame step readback mismatch");

  chk_fill_value: assert property (
    clk_en && src_data_valid && fill_on |=> dst_write && dst_data == $past(fill_pat))
    else $error("fill value not written");

  chk_key_drop: assert property (
    clk_en && src_data_valid && !fill_on && transparent_on && key_match |=> !dst_write)
    else $error("key match element was written");

  chk_key_pass: assert property (
    clk_en && src_data_valid && !fill_on && transparent_on && !key_match
    |=> dst_write && dst_data == $past(src_data))
    else $error("non key element not forwarded");

  chk_src_postinc: assert property (
    clk_en && src_access && !load_start && src_mode == mode_post_inc ##1 $stable(active_ch)
    |-> src_addr == $past(src_addr) + $past(size_bytes))
    else $error("source counter did not step by element size");

  chk_dst_shared_step: assert property (
    clk_en && dst_access && !load_start && dst_mode == mode_single_index
    && !sep_index ##1 $stable(active_ch)
    |-> dst_addr == $past(dst_addr) + sext($past(src_elem_arr[active_ch])))
    else $error("destination did not use source element step");

  chk_snap_read: assert property (
    clk_en && reg_rd && reg_addr[OFF_W-1:0] == OFF_SRC_SNAP
    && reg_addr[REG_ADDR_W-1:OFF_W] == active_ch
    |=> reg_rvalid && reg_rdata == $past(src_addr[REG_W-1:0]))
    else $error("source snapshot readback mismatch");

  chk_hold_frozen: assert property (
    !clk_en |=> $stable(dst_data) && $stable(reg_rdata) && $stable(dst_write)
    && (dst_addr == $past(dst_addr) || active_ch != $past(active_ch)))
    else $error("state changed while clock enable low");

endmodule

// ==== rtl/dma_index_colour_pkg.sv ====
// Shared constants and types for the channel index, counter and colour block
package dma_index_colour_pkg;

  // Channel count and register map geometry
  localparam int CHAN_COUNT  = 16;
  localparam int CH_W        = 4;
  localparam int REG_ADDR_W  = 10;
  localparam int OFF_W       = 6;
  localparam int ADDR_W      = 32;
  localparam int DATA_W      = 32;
  localparam int REG_W       = 16;

  // Byte offsets inside one channel's 0x40-byte window
  localparam logic [OFF_W-1:0] OFF_SRC_FRAME   = 6'h14;
  localparam logic [OFF_W-1:0] OFF_SRC_ELEMENT = 6'h16;
  localparam logic [OFF_W-1:0] OFF_SRC_SNAP    = 6'h18;
  localparam logic [OFF_W-1:0] OFF_DST_SNAP    = 6'h1a;
  localparam logic [OFF_W-1:0] OFF_DST_ELEMENT = 6'h1c;
  localparam logic [OFF_W-1:0] OFF_DST_FRAME   = 6'h1e;
  localparam logic [OFF_W-1:0] OFF_COLOUR_LOW  = 6'h20;
  localparam logic [OFF_W-1:0] OFF_COLOUR_HIGH = 6'h22;

  // Reset value of every held register
  localparam logic [REG_W-1:0]  REG_RESET  = 16'h0000;
  localparam logic [ADDR_W-1:0] ADDR_RESET = 32'h0000_0000;

  // Control word bit positions
  localparam int CTRL_SEP_INDEX_BIT   = 10;
  localparam int CTRL2_FILL_BIT       = 0;
  localparam int CTRL2_TRANSPARENT_BIT = 1;

  // Element access size
  typedef enum logic [1:0]
  {
    byte_access     = 2'b00,
    halfword_access = 2'b01,
    word_access     = 2'b10
  } elem_size_type;

  // Address stepping mode of one port
  typedef enum logic [1:0]
  {
    mode_constant     = 2'b00,
    mode_post_inc     = 2'b01,
    mode_single_index = 2'b10,
    mode_double_index = 2'b11
  } addr_mode_type;

endpackage

// ==== testbench/src_port_model.sv ====
// Behavioural source-port memory that hands elements to the block
`timescale 1ns/1ns
module src_port_model
(
  // Clock
  input  wire logic        ref_clk,
  // Element stream toward the block
  output logic      [31:0] src_data,
  output logic             src_data_valid
);
  logic [31:0] last_data;

  // Idle bus starts invalid with all ones on the data lines
  initial
  begin
    last_data      = 32'h0;
    src_data       = 32'hffff_ffff;
    src_data_valid = 1'b0;
  end

  // Offer one element after gap idle cycles; idle cycles alternate between inverted and old data
  task automatic send(input logic [31:0] d, input int gap);
    repeat (gap)
    begin
      src_data_valid = 1'b0;
      src_data       = ~last_data;
      last_data      = ~last_data;
      @(posedge ref_clk);
      #5;
    end
    src_data_valid = 1'b1;
    src_data       = d;
    last_data      = d;
    @(posedge ref_clk);
    #5;
  endtask

  // Release the bus after the last element
  task automatic rest;
    src_data_valid = 1'b0;
    src_data       = ~last_data;
  endtask
endmodule

// ==== testbench/dma_channel_index_counter_color_tb_top.sv ====
// Self-checking bench for the channel index, counter and colour block
`timescale 1ns/1ns
module dma_channel_index_counter_color_tb_top
  import dma_index_colour_pkg::*;
;
  logic ref_clk, reset, clk_en, reg_wr, reg_rd, reg_rvalid, load_start;
  logic src_access, src_frame_end, dst_access, dst_frame_end, src_data_valid, dst_write;
  logic [REG_ADDR_W-1:0] reg_addr;
  logic [15:0]           reg_wdata, reg_rdata, ctl, ctl2;
  logic [3:0]            active_ch;
  elem_size_type         elem_size;
  addr_mode_type         src_mode, dst_mode;
  logic [31:0]           src_start, dst_start, src_addr, dst_addr, src_data, dst_data;
  logic [31:0]           exp_s, exp_d, key, mask;
  logic [15:0]           v[16][6];
  logic [15:0]           rq[$];
  logic [31:0]           wq[$];
  logic [5:0]            offs[6];
  int                    n_errors, check_count, seed;

  dma_index_colour_channel dut (.ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .active_ch(active_ch),
    .channel_control_word(ctl), .channel_control_word_two(ctl2), .elem_size(elem_size),
    .src_mode(src_mode), .dst_mode(dst_mode), .load_start(load_start),
    .src_start(src_start), .dst_start(dst_start), .src_access(src_access),
    .src_frame_end(src_frame_end), .dst_access(dst_access), .dst_frame_end(dst_frame_end),
    .src_addr(src_addr), .dst_addr(dst_addr), .src_data(src_data),
    .src_data_valid(src_data_valid), .dst_data(dst_data), .dst_write(dst_write));

  src_port_model pm (.ref_clk(ref_clk), .src_data(src_data), .src_data_valid(src_data_valid));

  // Clock
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  function automatic logic [31:0] r32();
    return $random(seed);
  endfunction

  // Expected address step for one access
  function automatic logic [31:0] stp(int m, int z, logic [15:0] ei, logic [15:0] fi, int f);
    if (m == 1) return 32'h1 << z;
    if (m == 2 || (m == 3 && f == 0)) return {{16{ei[15]}}, ei};
    if (m == 3) return {{16{fi[15]}}, fi};
    return 32'h0;
  endfunction

  task automatic tick;
    @(posedge ref_clk);
    #5;
  endtask

  task automatic cmp(logic [31:0] g, logic [31:0] e, string m);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, g, e);
    end
  endtask

  // Strobes stay high across back-to-back calls; idle drops them
  task automatic wr(logic [3:0] c, logic [5:0] o, logic [15:0] d);
    reg_addr  = {c, o};
    reg_wdata = d;
    reg_rd    = 1'b0;
    reg_wr    = 1'b1;
    tick;
  endtask

  task automatic rd(logic [3:0] c, logic [5:0] o, logic [15:0] e);
    rq.push_back(e);
    reg_addr = {c, o};
    reg_wr   = 1'b0;
    reg_rd   = 1'b1;
    tick;
  endtask

  task automatic idle(int n);
    reg_wr     = 1'b0;
    reg_rd     = 1'b0;
    load_start = 1'b0;
    src_access = 1'b0;
    dst_access = 1'b0;
    repeat (n) tick;
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Monitor: oldest note is compared with each result as it appears
  always @(posedge ref_clk)
  begin
    #1;
    if (reg_rvalid === 1'b1)
    begin
      if (rq.size() == 0) cmp(32'h0, 32'h1, "read answer without request");
      else cmp({16'h0, reg_rdata}, {16'h0, rq.pop_front()}, "read data");
    end
    if (dst_write === 1'b1)
    begin
      if (wq.size() == 0) cmp(32'h0, 32'h1, "destination write not expected");
      else cmp(dst_data, wq.pop_front(), "destination data");
    end
  end

  // Watchdog
  initial
  begin
    #(4000 * 50);
    n_errors++;
    $display("unexpected at %0t: timeout", $time);
    test_done;
  end

  initial
  begin
    seed = 20811;
    offs = '{OFF_SRC_FRAME, OFF_SRC_ELEMENT, OFF_DST_ELEMENT, OFF_DST_FRAME,
             OFF_COLOUR_LOW, OFF_COLOUR_HIGH};
    {reset, clk_en} = 2'b11;
    {reg_wr, reg_rd, load_start, src_access, dst_access, src_frame_end, dst_frame_end} = '0;
    {reg_addr, reg_wdata, ctl, ctl2, active_ch, src_start, dst_start} = '0;
    elem_size = byte_access;
    src_mode  = mode_constant;
    dst_mode  = mode_constant;
    repeat (2) @(posedge ref_clk);
    #5;
    reset = 1'b0;
    // Reset values of every register of one channel
    for (int k = 0; k < 6; k++) rd(4'h3, offs[k], REG_RESET);
    rd(4'h3, OFF_SRC_SNAP, 16'h0);
    rd(4'h3, OFF_DST_SNAP, 16'h0);
    idle(3);
    $display("test reset done");
    // Distinct values in every channel, snapshot and unmapped writes ignored
    for (int c = 0; c < 16; c++)
      for (int k = 0; k < 6; k++)
      begin
        v[c][k] = 16'(r32());
        wr(c[3:0], offs[k], v[c][k]);
      end
    v[5][1] = 16'hfffc;
    wr(4'h5, OFF_SRC_ELEMENT, v[5][1]);
    for (int c = 0; c < 16; c++) wr(c[3:0], OFF_SRC_SNAP, 16'(r32()));
    wr(4'h9, 6'h3e, 16'hffff);
    // Write then read back the same step register in the next cycle
    v[7][0] = 16'(r32());
    wr(4'h7, OFF_SRC_FRAME, v[7][0]);
    rd(4'h7, OFF_SRC_FRAME, v[7][0]);
    for (int c = 0; c < 16; c++)
    begin
      for (int k = 0; k < 6; k++) rd(c[3:0], offs[k], v[c][k]);
      rd(c[3:0], OFF_SRC_SNAP, 16'h0);
    end
    rd(4'h9, 6'h3e, 16'h0);
    idle(3);
    $display("test registers done");
    // Address counters on channel 5, all modes, sizes and frame ends back to back
    active_ch  = 4'h5;
    src_start  = r32();
    dst_start  = r32();
    load_start = 1'b1;
    tick;
    idle(1);
    exp_s = src_start;
    exp_d = dst_start;
    cmp(src_addr, exp_s, "source load");
    for (int sep = 0; sep < 2; sep++)
    begin
      ctl = {5'h0, sep[0], 10'h0};
      for (int m = 0; m < 4; m++)
        for (int z = 0; z < 3; z++)
          for (int f = 0; f < 2; f++)
          begin
            src_mode      = addr_mode_type'(m);
            dst_mode      = addr_mode_type'(m);
            elem_size     = elem_size_type'(z);
            src_frame_end = f[0];
            dst_frame_end = f[0];
            src_access    = 1'b1;
            dst_access    = 1'b1;
            tick;
            exp_s = exp_s + stp(m, z, v[5][1], v[5][0], f);
            exp_d = exp_d + stp(m, z, sep ? v[5][2] : v[5][1], sep ? v[5][3] : v[5][0], f);
            cmp(src_addr, exp_s, "source address");
            cmp(dst_addr, exp_d, "destination address");
          end
    end
    idle(1);
    rd(4'h5, OFF_SRC_SNAP, exp_s[15:0]);
    rd(4'h5, OFF_DST_SNAP, exp_d[15:0]);
    idle(3);
    // Clock enable low freezes counters and ignores a held read
    clk_en     = 1'b0;
    reg_rd     = 1'b1;
    src_access = 1'b1;
    dst_access = 1'b1;
    repeat (2) tick;
    clk_en = 1'b1;
    idle(2);
    cmp(src_addr, exp_s, "frozen source counter");
    cmp(dst_addr, exp_d, "frozen destination counter");
    $display("test counters done");
    // Fill, colour key and plain copy for each element size
    for (int z = 0; z < 3; z++)
    begin
      elem_size = elem_size_type'(z);
      mask = z == 0 ? 32'hff : z == 1 ? 32'hffff : 32'hffff_ffff;
      key  = {v[5][5], v[5][4]} & mask;
      ctl2 = 16'h1;
      wq.push_back(key);
      pm.send(r32(), int'(r32() & 32'h1));
      ctl2 = 16'h2;
      pm.send(key | (r32() & ~mask), 0);
      wq.push_back(key ^ 32'h1);
      pm.send(key ^ 32'h1, 1);
      ctl2 = 16'h0;
      exp_d = r32() & mask;
      wq.push_back(exp_d);
      pm.send(exp_d, 0);
    end
    pm.rest();
    idle(4);
    cmp(rq.size() + wq.size(), 32'h0, "results outstanding");
    $display("test colour done");
    test_done;
  end
endmodule
